// *** hw/lpt_low_power_counter.sv ***
// Function
// - the counter counts upward in 16 bits up to a 16-bit autoreload value; in encoder mode it also counts down, wrapping from 0 to the autoreload value.
// - a 16-bit compare value drives the output as a single pulse or as PWM by configuration.
// - continuous mode counts forever, one-shot mode makes one run per start except in encoder mode, which keeps running.
// - counting starts on a software command or a hardware trigger, chosen by configuration.
// - the counting clock is chosen among crystal, either RC, the fast RC or the bus clock.
// - edges on the external input pin can be counted with no internal source running.
// - external inputs pass a programmable glitch filter that drops short pulses.
// - quadrature encoder counting exists only in the first instance.
// - with a low-speed or external clock the timer keeps counting in stop and can wake.
// - the first instance lives through stop levels 0 to 2, the second only 0 and 1.

`include "lpt_map.svh"

module lpt_low_power_counter
    import lpt_pkg::*;
#(
    parameter bit ENC_EN = 1'b1,
    parameter logic [1:0] MAX_STOP = `LPT_MAX_STOP_FIRST
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic [2:0] i_clk_sel,
    input wire logic i_low_speed_crystal_clock,
    input wire logic i_low_speed_rc_clock_a,
    input wire logic i_low_speed_rc_clock_b,
    input wire logic i_high_speed_rc_clock,
    input wire logic i_ext_pin,
    input wire logic i_trig_pin,
    input wire logic i_enc_b_pin,
    input wire logic i_trig_hw,
    input wire logic i_sw_start,
    input wire logic i_oneshot,
    input wire logic i_pwm_mode,
    input wire logic [1:0] i_filt_len,
    input wire logic i_enc_mode,
    input wire logic [15:0] i_arr,
    input wire logic [15:0] i_cmp,
    input wire logic i_stop,
    input wire logic [1:0] i_stop_level,
    input wire logic i_wake_cmp_en,
    input wire logic i_wake_arr_en,
    input wire logic i_cmp_clr,
    input wire logic i_arr_clr,
    output logic [15:0] o_count,
    output logic o_out,
    output logic o_cmp_flag,
    output logic o_arr_flag,
    output logic o_running,
    output logic o_wakeup
);
    import lpt_pkg::*;

    lpt_state_t state_reg;
    lpt_state_t state_next;
    logic tick;
    logic dn;
    logic enc_act;
    logic hw_trig;
    logic gate_ok;
    logic [3:0] need;

    function automatic logic [3:0] filt_need(input logic [1:0] len);
        unique case (len)
            2'h0: filt_need = `LPT_FILT_N0;
            2'h1: filt_need = `LPT_FILT_N1;
            2'h2: filt_need = `LPT_FILT_N2;
            2'h3: filt_need = `LPT_FILT_N3;
        endcase
    endfunction

    // returns {filtered level, run length}
    function automatic logic [3:0] filt_step(input logic raw, input logic cur,
                                             input logic [2:0] run, input logic [3:0] n);
        logic [3:0] run1;
        run1 = {1'b0, run} + 4'h1;
        if (raw == cur)
            filt_step = {cur, 3'h0};
        else if (run1 >= n)
            filt_step = {raw, 3'h0};
        else
            filt_step = {cur, run1[2:0]};
    endfunction

    function automatic logic lp_src(input logic [2:0] sel);
        lp_src = (sel == `LPT_SEL_XTAL) || (sel == `LPT_SEL_RC_A) ||
                 (sel == `LPT_SEL_RC_B) || (sel == `LPT_SEL_EXT);
    endfunction

    assign need = filt_need(i_filt_len);
    assign enc_act = ENC_EN && i_enc_mode;
    assign hw_trig = state_reg.f[1] && !state_reg.fp[1];
    // fast source and bus clock are gated off in stop, deep levels per instance
    assign gate_ok = !i_stop || (lp_src(i_clk_sel) && (i_stop_level <= MAX_STOP));

    always_comb
    begin
        logic a_r;
        logic a_f;
        logic raw_tick;
        a_r = state_reg.f[0] && !state_reg.fp[0];
        a_f = !state_reg.f[0] && state_reg.fp[0];
        raw_tick = 1'b0;
        dn = 1'b0;
        if (enc_act)
        begin
            raw_tick = a_r || a_f;
            dn = (a_r && state_reg.f[2]) || (a_f && !state_reg.f[2]);
        end
        else
        begin
            // the fast rc is far above this clock; its edges alias when sampled
            unique case (i_clk_sel)
                `LPT_SEL_XTAL, `LPT_SEL_RC_A, `LPT_SEL_RC_B, `LPT_SEL_HS_RC:
                    raw_tick = state_reg.s2[i_clk_sel[1:0]] && !state_reg.p[i_clk_sel[1:0]];
                `LPT_SEL_BUS: raw_tick = 1'b1;
                `LPT_SEL_EXT: raw_tick = a_r;
                default: raw_tick = 1'b0;
            endcase
        end
        tick = raw_tick && gate_ok;
    end

    always_comb
    begin
        logic [3:0] fs;
        logic cmp_hit;
        logic arr_hit;
        fs = 4'h0;
        state_next = state_reg;
        cmp_hit = 1'b0;
        arr_hit = 1'b0;
        state_next.s1 = {i_enc_b_pin, i_trig_pin, i_ext_pin, i_high_speed_rc_clock,
                         i_low_speed_rc_clock_b, i_low_speed_rc_clock_a,
                         i_low_speed_crystal_clock};
        state_next.s2 = state_reg.s1;
        state_next.p = state_reg.s2[3:0];
        state_next.fp = state_reg.f;
        for (int i = 0; i < `LPT_FILT_LANES; i++)
        begin
            fs = filt_step(state_reg.s2[4+i], state_reg.f[i], state_reg.fc[3*i +: 3], need);
            state_next.f[i] = fs[3];
            state_next.fc[3*i +: 3] = fs[2:0];
        end
        if (!i_enable)
        begin
            state_next.fsm = LPT_IDLE;
            state_next.cnt = `LPT_CNT_ZERO;
            state_next.out = 1'b0;
        end
        else
        begin
            unique case (state_reg.fsm)
                LPT_IDLE:
                begin
                    state_next.out = 1'b0;
                    if (i_trig_hw ? hw_trig : i_sw_start)
                    begin
                        state_next.fsm = LPT_RUN;
                        state_next.cnt = `LPT_CNT_ZERO;
                    end
                end
                LPT_RUN:
                begin
                    if (tick)
                    begin
                        cmp_hit = (state_reg.cnt == i_cmp);
                        if (dn)
                            state_next.cnt = (state_reg.cnt == `LPT_CNT_ZERO) ? i_arr :
                                             state_reg.cnt - `LPT_CNT_ONE;
                        else if (state_reg.cnt == i_arr)
                        begin
                            arr_hit = 1'b1;
                            state_next.cnt = `LPT_CNT_ZERO;
                            if (i_oneshot && !enc_act)
                                state_next.fsm = LPT_IDLE;
                        end
                        else
                            state_next.cnt = state_reg.cnt + `LPT_CNT_ONE;
                    end
                    // pwm: high from compare to reload; pulse: one count period
                    if (i_pwm_mode)
                        state_next.out = (state_next.cnt >= i_cmp) &&
                                         (state_next.fsm == LPT_RUN);
                    else if (tick)
                        state_next.out = (state_next.cnt == i_cmp) &&
                                         (state_next.fsm == LPT_RUN);
                end
            endcase
        end
        // set beats clear in the same cycle
        state_next.cmp_f = cmp_hit || (state_reg.cmp_f && !i_cmp_clr);
        state_next.arr_f = arr_hit || (state_reg.arr_f && !i_arr_clr);
        state_next.wake = i_stop && ((state_next.cmp_f && i_wake_cmp_en) ||
                                     (state_next.arr_f && i_wake_arr_en));
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign o_count = state_reg.cnt;
    assign o_out = state_reg.out;
    assign o_cmp_flag = state_reg.cmp_f;
    assign o_arr_flag = state_reg.arr_f;
    assign o_running = (state_reg.fsm == LPT_RUN);
    assign o_wakeup = state_reg.wake;

    sequence s_run_tick;
        i_enable && state_reg.fsm == LPT_RUN && tick;
    endsequence

    sequence s_wrap;
        s_run_tick ##0 !dn && state_reg.cnt == i_arr;
    endsequence

    property p_count_up;
        @(posedge i_clk) disable iff (!i_resetn)
        s_run_tick ##0 !enc_act && state_reg.cnt != i_arr |=>
            state_reg.cnt == $past(state_reg.cnt) + `LPT_CNT_ONE;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step up");

    property p_wrap;
        @(posedge i_clk) disable iff (!i_resetn)
        s_wrap |=> state_reg.cnt == `LPT_CNT_ZERO && state_reg.arr_f;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap or reload flag");

    property p_oneshot;
        @(posedge i_clk) disable iff (!i_resetn)
        s_wrap ##0 i_oneshot && !enc_act |=> !o_running ##1 (!o_running || $past(i_sw_start)
            || $past(hw_trig));
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot kept running");

    property p_cmp_flag;
        @(posedge i_clk) disable iff (!i_resetn)
        s_run_tick ##0 state_reg.cnt == i_cmp |=> o_cmp_flag;
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag missing");

    property p_sw_start;
        @(posedge i_clk) disable iff (!i_resetn)
        i_enable && !o_running && !i_trig_hw && i_sw_start |=>
            o_running && o_count == `LPT_CNT_ZERO;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software start ignored");

    property p_pwm;
        @(posedge i_clk) disable iff (!i_resetn)
        i_enable && i_pwm_mode && o_running ##1 i_pwm_mode && o_running &&
            $stable(i_cmp) |-> o_out == (o_count >= i_cmp);
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm level wrong");

    property p_stop_gate;
        @(posedge i_clk) disable iff (!i_resetn)
        i_enable && o_running && i_stop && i_stop_level > MAX_STOP |=>
            o_count == $past(o_count);
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("counted in too deep a stop");

    property p_no_enc;
        @(posedge i_clk) disable iff (!i_resetn)
        !ENC_EN && i_enc_mode ##0 s_run_tick |-> !dn;
    endproperty
    a_no_enc: assert property (p_no_enc) else $error("encoder active in second instance");

    property p_filter;
        @(posedge i_clk) disable iff (!i_resetn)
        $changed(state_reg.f[0]) |->
            {1'b0, $past(state_reg.fc[2:0])} + 4'h1 >= $past(need);
    endproperty
    a_filter: assert property (p_filter) else $error("glitch passed the filter");

    property p_wake;
        @(posedge i_clk) disable iff (!i_resetn)
        i_stop && i_wake_arr_en && o_arr_flag && !i_arr_clr |=> o_wakeup;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on reload flag");
endmodule

// *** hw/lpt_map.svh ***
`ifndef LPT_MAP_SVH
`define LPT_MAP_SVH

// counting clock selection codes
`define LPT_SEL_XTAL 3'h0
`define LPT_SEL_RC_A 3'h1
`define LPT_SEL_RC_B 3'h2
`define LPT_SEL_HS_RC 3'h3
`define LPT_SEL_BUS 3'h4
`define LPT_SEL_EXT 3'h5

`define LPT_CNT_W 16
`define LPT_CNT_ZERO 16'h0000
`define LPT_CNT_ONE 16'h0001

// glitch filter: stable samples needed per length code
`define LPT_FILT_N0 4'h1
`define LPT_FILT_N1 4'h2
`define LPT_FILT_N2 4'h4
`define LPT_FILT_N3 4'h8

// deepest stop level each instance survives
`define LPT_MAX_STOP_FIRST 2'h2
`define LPT_MAX_STOP_SECOND 2'h1

// synchroniser lanes
`define LPT_PIN_N 7
`define LPT_FILT_LANES 3

`endif

// *** hw/lpt_pkg.sv ***
`include "lpt_map.svh"

package lpt_pkg;

    typedef enum logic [0:0] {
        LPT_IDLE = 1'b0,
        LPT_RUN = 1'b1
    } lpt_fsm_t;

    typedef struct packed {
        lpt_fsm_t fsm;
        logic [`LPT_CNT_W-1:0] cnt;
        logic out;
        logic cmp_f;
        logic arr_f;
        logic wake;
        logic [`LPT_PIN_N-1:0] s1;
        logic [`LPT_PIN_N-1:0] s2;
        logic [3:0] p;
        logic [`LPT_FILT_LANES-1:0] f;
        logic [`LPT_FILT_LANES-1:0] fp;
        logic [3*`LPT_FILT_LANES-1:0] fc;
    } lpt_state_t;

endpackage

// *** bench/lpt_src_model.sv ***
module lpt_src_model (
    input wire logic i_burst,
    input wire logic i_glitch,
    input wire logic i_trig,
    input wire logic i_enc_b,
    output logic o_xtal,
    output logic o_rc_a,
    output logic o_rc_b,
    output logic o_fast_rc,
    output logic o_ext_pin,
    output logic o_trig_pin,
    output logic o_enc_b_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // burst and spike drive separate nets so the pin has one driver
    logic ext_burst;
    logic ext_spike;
    // low-speed sources sped up so a run stays short
    initial
    begin
        o_xtal = 0;
        o_rc_a = 0;
        o_rc_b = 0;
        o_fast_rc = 0;
        ext_burst = 0;
        ext_spike = 0;
    end
    always #400 o_xtal = ~o_xtal;
    always #450 o_rc_a = ~o_rc_a;
    always #350 o_rc_b = ~o_rc_b;
    always #31 o_fast_rc = ~o_fast_rc;
    // three pulses per burst, pin stands low between bursts
    always @(posedge i_burst)
    begin
        repeat (3)
        begin
            #400 ext_burst = 1;
            #400 ext_burst = 0;
        end
    end
    // one-sample spike, offset so it spans exactly one sampling edge
    always @(posedge i_glitch)
    begin
        #30 ext_spike = 1;
        #100 ext_spike = 0;
    end
    assign o_ext_pin = ext_burst | ext_spike;
    assign o_trig_pin = i_trig;
    assign o_enc_b_pin = i_enc_b;
endmodule

// *** bench/low_power_timer_tb_top.sv ***
module low_power_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, en = 0, st = 0, os = 0, pwm = 0, thw = 0, stop = 0;
    logic wce = 0, wae = 0, cclr = 0, aclr = 0, burst = 0, gl = 0, trg = 0;
    logic [2:0] sel = 3'h4;
    logic [1:0] flt = 2'h0, lvl = 2'h0;
    logic [15:0] arr = 16'h0002, cmp = 16'h0001, cnt;
    logic xt, ra, rb, hs, ep, tp, out, cf, af, run, wk, ebp;
    logic enc = 0, eb = 0;
    logic [15:0] cnt2;
    int fails = 0, compares = 0;

    always #50 clk = ~clk;

    lpt_src_model src_u (.i_burst(burst), .i_glitch(gl), .i_trig(trg), .i_enc_b(eb),
        .o_xtal(xt), .o_rc_a(ra), .o_rc_b(rb), .o_fast_rc(hs), .o_ext_pin(ep),
        .o_trig_pin(tp), .o_enc_b_pin(ebp));

    lpt_low_power_counter dut_u (.i_clk(clk), .i_resetn(rstn), .i_enable(en),
        .i_clk_sel(sel), .i_low_speed_crystal_clock(xt), .i_low_speed_rc_clock_a(ra),
        .i_low_speed_rc_clock_b(rb), .i_high_speed_rc_clock(hs), .i_ext_pin(ep),
        .i_trig_pin(tp), .i_enc_b_pin(ebp), .i_trig_hw(thw), .i_sw_start(st),
        .i_oneshot(os), .i_pwm_mode(pwm), .i_filt_len(flt), .i_enc_mode(enc),
        .i_arr(arr), .i_cmp(cmp), .i_stop(stop), .i_stop_level(lvl),
        .i_wake_cmp_en(wce), .i_wake_arr_en(wae), .i_cmp_clr(cclr), .i_arr_clr(aclr),
        .o_count(cnt), .o_out(out), .o_cmp_flag(cf), .o_arr_flag(af),
        .o_running(run), .o_wakeup(wk));

    // second instance: no encoder, survives stop levels 0 and 1 only
    lpt_low_power_counter #(.ENC_EN(1'b0), .MAX_STOP(2'h1)) dut2_u (.i_clk(clk),
        .i_resetn(rstn), .i_enable(en),
        .i_clk_sel(sel), .i_low_speed_crystal_clock(xt), .i_low_speed_rc_clock_a(ra),
        .i_low_speed_rc_clock_b(rb), .i_high_speed_rc_clock(hs), .i_ext_pin(ep),
        .i_trig_pin(tp), .i_enc_b_pin(ebp), .i_trig_hw(thw), .i_sw_start(st),
        .i_oneshot(os), .i_pwm_mode(pwm), .i_filt_len(flt), .i_enc_mode(enc),
        .i_arr(arr), .i_cmp(cmp), .i_stop(stop), .i_stop_level(lvl),
        .i_wake_cmp_en(wce), .i_wake_arr_en(wae), .i_cmp_clr(cclr), .i_arr_clr(aclr),
        .o_count(cnt2), .o_out(), .o_cmp_flag(), .o_arr_flag(),
        .o_running(), .o_wakeup());

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task conclude;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // disable and clear flags so each test starts from idle
    task rearm;
        @(posedge clk);
        en <= 0;
        cclr <= 1;
        aclr <= 1;
        @(posedge clk);
        en <= 1;
        cclr <= 0;
        aclr <= 0;
    endtask

    task start;
        @(posedge clk);
        st <= 1;
        @(posedge clk);
        st <= 0;
    endtask

    task t_walk;
        logic [7:0] t [4];
        t = '{8'h08, 8'h1c, 8'h2e, 8'h03};
        rearm;
        pwm <= 1;
        os <= 1;
        start;
        // first look is at the edge that took the start
        for (int k = 0; k < 4; k++)
        begin
            #1;
            chk("walk", {cnt[11:0], run, out, cf, af}, {8'h00, t[k]});
            @(posedge clk);
        end
        $display("done walk");
    endtask

    task t_cont;
        rearm;
        os <= 0;
        pwm <= 0;
        arr <= 16'h0003;
        cmp <= 16'h0002;
        start;
        // a second start mid-run must not disturb the count
        for (int k = 1; k < 10; k++)
        begin
            @(posedge clk);
            st <= (k == 4);
            #1;
            chk("cont count", cnt, 16'(k % 4));
            chk("cont out", out, 16'(k % 4 == 2));
        end
        @(posedge clk);
        en <= 0;
        repeat (2) @(posedge clk);
        #1;
        chk("disabled", {cnt[14:0], run}, 16'h0000);
        chk("flag kept", af, 1);
        $display("done cont");
    endtask

    task t_ext;
        rearm;
        sel <= 3'h5;
        arr <= 16'hffff;
        start;
        @(posedge clk);
        burst <= 1;
        repeat (30) @(posedge clk);
        burst <= 0;
        flt <= 2'h1;
        #1;
        chk("ext count", cnt, 16'h0003);
        @(posedge clk);
        gl <= 1;
        @(posedge clk);
        gl <= 0;
        repeat (10) @(posedge clk);
        #1;
        chk("glitch", cnt, 16'h0003);
        @(posedge clk);
        burst <= 1;
        repeat (30) @(posedge clk);
        burst <= 0;
        #1;
        chk("filtered count", cnt, 16'h0006);
        $display("done ext");
    endtask

    // b held high: each a rise steps down, each a fall steps up
    task t_enc;
        rearm;
        sel <= 3'h5;
        enc <= 1;
        eb <= 1;
        os <= 1;
        arr <= 16'hffff;
        start;
        @(posedge clk);
        burst <= 1;
        repeat (30) @(posedge clk);
        burst <= 0;
        #1;
        chk("enc count", cnt, 16'h0000);
        chk("enc wrap", af, 1);
        chk("enc oneshot", run, 1);
        chk("second count", cnt2, 16'h0003);
        @(posedge clk);
        enc <= 0;
        eb <= 0;
        $display("done enc");
    endtask

    task t_trig;
        int n;
        rearm;
        sel <= 3'h4;
        flt <= 2'h0;
        thw <= 1;
        os <= 1;
        arr <= 16'h0005;
        start;
        repeat (3) @(posedge clk);
        #1;
        chk("sw ignored", run, 0);
        @(posedge clk);
        trg <= 1;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (run !== 1'b1 && n < 20);
        chk("hw start", run, 1);
        if (run !== 1'b1)
            conclude;
        @(posedge clk);
        trg <= 0;
        thw <= 0;
        $display("done trig");
    endtask

    task t_stop;
        logic [5:0] t [5];
        // sel, stop level, expected to keep counting
        t = '{6'h05, 6'h06, 6'h18, 6'h0b, 6'h11};
        for (int i = 0; i < 5; i++)
        begin
            rearm;
            sel <= t[i][5:3];
            lvl <= t[i][2:1];
            stop <= 1;
            wce <= 1;
            os <= 0;
            arr <= 16'hffff;
            cmp <= 16'h0001;
            start;
            repeat (50) @(posedge clk);
            #1;
            chk("stop count", cnt != 0, t[i][0]);
            chk("wake", wk, t[i][0]);
            chk("second stop", cnt2 != 0, t[i][0] && t[i][2:1] < 2'h2);
        end
        @(posedge clk);
        stop <= 0;
        $display("done stop");
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1;
        t_walk;
        t_cont;
        t_ext;
        t_enc;
        t_trig;
        t_stop;
        conclude;
    end
endmodule
